// File: rtl/trp_defines.svh
// Offsets, field positions, reset values and bit positions of the receive packer
`ifndef TRP_DEFINES_SVH
`define TRP_DEFINES_SVH
`define TRP_OFS_CTRL 8'h00
`define TRP_OFS_STATUS 8'h04
`define TRP_OFS_VIOL 8'h08
`define TRP_OFS_WORDS 8'h0c
`define TRP_OFS_LAST 8'h10
`define TRP_CTRL_WIDTH_LSB 0
`define TRP_CTRL_PIPE 4
`define TRP_CTRL_EN 8
`define TRP_CTRL_MASK 32'h0000_0113
`define TRP_CTRL_RST 32'h0000_0000
`define TRP_STAT_SYNC_LOST 0
`define TRP_STAT_SYNC_LSB 8
`define TRP_HSIZE_WORD 3'h2
`define TRP_B_CTRL 8
`define TRP_B_ERR 9
`define TRP_B_SYNC 10
`define TRP_B_DERR 11
`define TRP_B_PAT 12
`define TRP_B_DEL 13
`define TRP_B_INS 14
`define TRP_B_RD 15
`define TRP_LANE_W 16
`define TRP_RAW_W 10
`define TRP_LANES 2
`endif

// File: rtl/trp_if.sv
// Interfaces between the packer top and its lane and statistics modules
`timescale 1ns/1ps
interface trp_lane_if;
  logic [9:0] raw;
  logic ctrl;
  logic err;
  logic sync;
  logic derr;
  logic pat;
  logic del;
  logic ins;
  logic [1:0] pipe_st;
  logic rd;
  logic active;
  logic pipe;
  trp_pkg::trp_width_t width;
  logic [15:0] slice;
  modport pack (input raw, ctrl, err, sync, derr, pat, del, ins, pipe_st, rd, active, pipe,
    width, output slice);
  modport core (output raw, ctrl, err, sync, derr, pat, del, ins, pipe_st, rd, active, pipe,
    width, input slice);
endinterface

interface trp_stat_if #(parameter int CNT_W = 16);
  logic viol;
  logic sync_drop;
  logic clr_viol;
  logic clr_sync;
  logic [CNT_W-1:0] viol_cnt;
  logic sync_lost;
  modport stat (input viol, sync_drop, clr_viol, clr_sync, output viol_cnt, sync_lost);
  modport core (output viol, sync_drop, clr_viol, clr_sync, input viol_cnt, sync_lost);
endinterface

// File: rtl/trp_lane.sv
// Maps one lane's decoder status onto its 16-bit slice of the receive bus
`timescale 1ns/1ps
`include "trp_defines.svh"
module trp_lane (
  trp_lane_if.pack lane
);
  logic [15:0] slice;

  always_comb begin
    slice = 16'h0000;
    if (lane.active) begin
      unique case (lane.width)
        trp_pkg::TRP_W10: begin
          slice[9:0] = lane.raw;
          slice[`TRP_B_SYNC] = lane.sync;
          slice[`TRP_B_DERR] = lane.derr;
          slice[`TRP_B_PAT] = lane.pat;
          // Raw words carry no PIPE status, so those bits stay low
          if (!lane.pipe) begin
            slice[`TRP_B_DEL] = lane.del;
            slice[`TRP_B_INS] = lane.ins;
          end
          slice[`TRP_B_RD] = lane.rd;
        end
        default: begin
          // Decoded layout, shared by 8-bit and each byte of 16-bit
          slice[7:0] = lane.raw[7:0];
          slice[`TRP_B_CTRL] = lane.ctrl;
          slice[`TRP_B_ERR] = lane.err;
          slice[`TRP_B_SYNC] = lane.sync;
          slice[`TRP_B_DERR] = lane.derr;
          slice[`TRP_B_PAT] = lane.pat;
          if (lane.pipe) begin
            slice[`TRP_B_INS:`TRP_B_DEL] = lane.pipe_st;
          end else begin
            slice[`TRP_B_DEL] = lane.del;
            slice[`TRP_B_INS] = lane.ins;
          end
          slice[`TRP_B_RD] = lane.rd;
        end
      endcase
    end
  end

  assign lane.slice = slice;
endmodule

// File: rtl/trp_pkg.sv
// Types shared by the receive packer modules
package trp_pkg;
  typedef enum logic [1:0] {
    TRP_W8 = 2'h0,
    TRP_W10 = 2'h1,
    TRP_W16 = 2'h2
  } trp_width_t;
endpackage

// File: rtl/trp_rx_pack.sv
// Receive packer top: AHB-Lite registers and the 32-bit receive bus toward fabric
//
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "trp_defines.svh"
module trp_rx_pack #(
  parameter int ADDR_W = 8,
  parameter int CNT_W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rx_valid,
  input wire logic [19:0] rx_raw,
  input wire logic [1:0] rx_ctrl,
  input wire logic [1:0] rx_err,
  input wire logic [1:0] rx_sync,
  input wire logic [1:0] rx_derr,
  input wire logic [1:0] rx_pat,
  input wire logic [1:0] rx_del,
  input wire logic [1:0] rx_ins,
  input wire logic [3:0] rx_pipe_st,
  input wire logic [1:0] rx_rd,
  output logic [31:0] rx_bus,
  output logic rx_bus_valid
);
  generate
    if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
      $error("ADDR_W must cover the register map and fit haddr");
    end
    if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
      $error("CNT_W must be between 1 and 32");
    end
  endgenerate

  localparam logic [ADDR_W-1:0] OFS_CTRL = ADDR_W'(`TRP_OFS_CTRL);
  localparam logic [ADDR_W-1:0] OFS_STATUS = ADDR_W'(`TRP_OFS_STATUS);
  localparam logic [ADDR_W-1:0] OFS_VIOL = ADDR_W'(`TRP_OFS_VIOL);
  localparam logic [ADDR_W-1:0] OFS_WORDS = ADDR_W'(`TRP_OFS_WORDS);
  localparam logic [ADDR_W-1:0] OFS_LAST = ADDR_W'(`TRP_OFS_LAST);

  // Bus slave state
  logic wr_pend_ff;
  logic nxt_wr_pend;
  logic [ADDR_W-1:0] wr_addr_ff;
  logic [ADDR_W-1:0] nxt_wr_addr;
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_hrdata;
  logic [31:0] ctrl_ff;
  logic [31:0] nxt_ctrl;
  logic [31:0] word_cnt_ff;
  logic [31:0] nxt_word_cnt;

  // Receive path state
  logic [31:0] bus_ff;
  logic [31:0] nxt_bus;
  logic bus_vld_ff;
  logic nxt_bus_vld;
  logic [1:0] sync_prev_ff;
  logic [1:0] nxt_sync_prev;

  logic addr_phase;
  logic rd_req;
  logic wr_ctrl;
  logic wr_status;
  logic wr_viol;
  logic wr_words;
  logic word_take;
  logic [1:0] lane_act;
  logic [1:0] lane_drop;
  logic [15:0] slice [`TRP_LANES];
  logic [31:0] ctrl_view;
  logic [31:0] status_view;
  logic [31:0] viol_view;
  trp_pkg::trp_width_t width;
  logic pipe_mode;
  logic enable;

  trp_stat_if #(.CNT_W(CNT_W)) st_if ();

  // Address phase, taken only when the bus is ready
  assign addr_phase = hsel && hready && htrans[1];
  assign rd_req = addr_phase && !hwrite;

  // Sub-word writes are ignored; only whole words reach the registers
  always_comb begin
    nxt_wr_pend = addr_phase && hwrite && (hsize == `TRP_HSIZE_WORD);
    nxt_wr_addr = wr_addr_ff;
    if (addr_phase) begin
      nxt_wr_addr = haddr[ADDR_W-1:0];
    end
  end

  assign wr_ctrl = wr_pend_ff && (wr_addr_ff == OFS_CTRL);
  assign wr_status = wr_pend_ff && (wr_addr_ff == OFS_STATUS);
  assign wr_viol = wr_pend_ff && (wr_addr_ff == OFS_VIOL);
  assign wr_words = wr_pend_ff && (wr_addr_ff == OFS_WORDS);

  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      nxt_ctrl = hwdata & `TRP_CTRL_MASK;
    end
  end

  // Code 2'h3 is not a width; it falls back to the 8-bit layout
  always_comb begin
    unique case (ctrl_ff[`TRP_CTRL_WIDTH_LSB +: 2])
      2'h1: width = trp_pkg::TRP_W10;
      2'h2: width = trp_pkg::TRP_W16;
      default: width = trp_pkg::TRP_W8;
    endcase
  end

  assign pipe_mode = ctrl_ff[`TRP_CTRL_PIPE];
  assign enable = ctrl_ff[`TRP_CTRL_EN];
  assign word_take = rx_valid && enable;

  // High lane only carries a byte in the 16-bit width
  assign lane_act[0] = 1'b1;
  assign lane_act[1] = (width == trp_pkg::TRP_W16);

  genvar g;
  generate
    for (g = 0; g < `TRP_LANES; g++) begin : g_lane
      trp_lane_if lane_if ();
      assign lane_if.raw = rx_raw[g*`TRP_RAW_W +: `TRP_RAW_W];
      assign lane_if.ctrl = rx_ctrl[g];
      assign lane_if.err = rx_err[g];
      assign lane_if.sync = rx_sync[g];
      assign lane_if.derr = rx_derr[g];
      assign lane_if.pat = rx_pat[g];
      assign lane_if.del = rx_del[g];
      assign lane_if.ins = rx_ins[g];
      assign lane_if.pipe_st = rx_pipe_st[g*2 +: 2];
      assign lane_if.rd = rx_rd[g];
      assign lane_if.active = lane_act[g];
      assign lane_if.pipe = pipe_mode;
      assign lane_if.width = width;
      assign slice[g] = lane_if.slice;
      // Alignment lost on an accepted word after it had been held
      assign lane_drop[g] = word_take && lane_act[g] && sync_prev_ff[g] && !rx_sync[g];
      trp_lane u_lane (
        .lane(lane_if.pack)
      );
    end
  endgenerate

  // Whole word is built from one sample, so no flag lags its payload
  always_comb begin
    nxt_bus = bus_ff;
    nxt_bus_vld = 1'b0;
    nxt_sync_prev = sync_prev_ff;
    if (word_take) begin
      nxt_bus = {slice[1], slice[0]};
      nxt_bus_vld = 1'b1;
      nxt_sync_prev = rx_sync & lane_act;
    end
  end

  // Raw 10-bit words are not decoded, so they carry no violations
  assign st_if.viol = word_take && (width != trp_pkg::TRP_W10) && |(rx_err & lane_act);
  assign st_if.sync_drop = |lane_drop;
  assign st_if.clr_viol = wr_viol;
  assign st_if.clr_sync = wr_status && hwdata[`TRP_STAT_SYNC_LOST];

  trp_stat #(
    .CNT_W(CNT_W)
  ) u_stat (
    .hclk(hclk),
    .hresetn(hresetn),
    .st(st_if.stat)
  );

  // Word counter wraps; a clear in the same cycle as a word leaves one
  always_comb begin
    nxt_word_cnt = word_cnt_ff;
    if (wr_words) begin
      nxt_word_cnt = 32'h0000_0000;
    end
    if (word_take) begin
      nxt_word_cnt = nxt_word_cnt + 32'h0000_0001;
    end
  end

  // Read data is registered at the address edge; control is forwarded
  // so a read right after a control write sees the new value
  assign ctrl_view = nxt_ctrl;
  always_comb begin
    status_view = 32'h0000_0000;
    status_view[`TRP_STAT_SYNC_LOST] = st_if.sync_lost;
    status_view[`TRP_STAT_SYNC_LSB +: 2] = sync_prev_ff;
  end
  assign viol_view = 32'(st_if.viol_cnt);

  always_comb begin
    nxt_hrdata = hrdata_ff;
    if (rd_req) begin
      unique case (haddr[ADDR_W-1:0])
        OFS_CTRL: nxt_hrdata = ctrl_view;
        OFS_STATUS: nxt_hrdata = status_view;
        OFS_VIOL: nxt_hrdata = viol_view;
        OFS_WORDS: nxt_hrdata = word_cnt_ff;
        OFS_LAST: nxt_hrdata = bus_ff;
        default: nxt_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
    end else begin
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= `TRP_CTRL_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      word_cnt_ff <= 32'h0000_0000;
    end else begin
      word_cnt_ff <= nxt_word_cnt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else begin
      hrdata_ff <= nxt_hrdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_ff <= 32'h0000_0000;
      bus_vld_ff <= 1'b0;
      sync_prev_ff <= 2'h0;
    end else begin
      bus_ff <= nxt_bus;
      bus_vld_ff <= nxt_bus_vld;
      sync_prev_ff <= nxt_sync_prev;
    end
  end

  // Zero wait states and no error responses
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign rx_bus = bus_ff;
  assign rx_bus_valid = bus_vld_ff;
endmodule

// File: rtl/trp_stat.sv
// Code violation counter and sticky loss-of-alignment flag
`timescale 1ns/1ps
module trp_stat #(
  parameter int CNT_W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  trp_stat_if.stat st
);
  logic [CNT_W-1:0] viol_cnt_ff;
  logic [CNT_W-1:0] nxt_viol_cnt;
  logic sync_lost_ff;
  logic nxt_sync_lost;

  always_comb begin
    nxt_viol_cnt = viol_cnt_ff;
    if (st.clr_viol) begin
      nxt_viol_cnt = '0;
    end
    // Event in the clearing cycle is still counted; saturates, never wraps
    if (st.viol && (nxt_viol_cnt != {CNT_W{1'b1}})) begin
      nxt_viol_cnt = nxt_viol_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
    end
    nxt_sync_lost = (sync_lost_ff && !st.clr_sync) || st.sync_drop;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      viol_cnt_ff <= '0;
      sync_lost_ff <= 1'b0;
    end else begin
      viol_cnt_ff <= nxt_viol_cnt;
      sync_lost_ff <= nxt_sync_lost;
    end
  end

  assign st.viol_cnt = viol_cnt_ff;
  assign st.sync_lost = sync_lost_ff;
endmodule

// File: verification/tb_top.sv
// Testbench for the receive packer
`timescale 1ns/1ps
module tb_top;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rx_valid = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rx_bus, r, hold, got_word;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  logic hreadyout, hresp, rx_bus_valid;
  logic [39:0] s = 0;
  logic [15:0] got_cnt;
  logic lost = 0;
  logic [1:0] sp = 0, act;
  int err_count = 0, num_checks = 0, cyc = 0, viol_exp = 0;
  always #4 hclk = ~hclk;
  trp_rx_pack dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_valid(rx_valid),
    .rx_raw(s[19:0]), .rx_ctrl(s[21:20]), .rx_err(s[23:22]), .rx_sync(s[25:24]),
    .rx_derr(s[27:26]), .rx_pat(s[29:28]), .rx_del(s[31:30]), .rx_ins(s[33:32]),
    .rx_pipe_st(s[37:34]), .rx_rd(s[39:38]), .rx_bus(rx_bus), .rx_bus_valid(rx_bus_valid));
  trp_fabric_sink u_sink (.hclk(hclk), .hresetn(hresetn), .rx_bus(rx_bus),
    .rx_bus_valid(rx_bus_valid), .got_word(got_word), .got_cnt(got_cnt));
  task report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      report_and_stop();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Address phase held until ready, then data phase until ready again
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= a; hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  function automatic logic [15:0] lexp(input logic [39:0] v, input int k, input logic w10,
      input logic pp);
    logic [15:0] e;
    e[15] = v[38+k];
    e[12] = v[28+k];
    e[11] = v[26+k];
    e[10] = v[24+k];
    e[14:13] = pp ? (w10 ? 2'h0 : v[34+2*k +: 2]) : {v[32+k], v[30+k]};
    e[9:0] = w10 ? v[10*k +: 10] : {v[22+k], v[20+k], v[10*k +: 8]};
    return e;
  endfunction
  // Back-to-back words; each is checked just after the edge that takes it
  task run(input logic [1:0] w, input logic pp, input logic en, input int n);
    logic [31:0] c;
    c = {23'h0, en, 3'h0, pp, 2'h0, w};
    ahb(1, 32'h0, c);
    ahb(0, 32'h0, 32'h0);
    chk(r, c);
    for (int i = 0; i <= n; i++) begin
      @(posedge hclk);
      rx_valid <= (i < n);
      s <= (i == 0) ? {40{1'b1}} : 40'h96_5ac3_e917 * (i + 1);
      #1;
      if (i > 0) begin
        chk({31'h0, rx_bus_valid}, {31'h0, en});
        chk(rx_bus, hold);
      end
      // The closing sample is never offered, so it must not move the expectations
      if (en && i < n) begin
        hold = (w == 2'h2) ? {lexp(s, 1, 0, pp), lexp(s, 0, 0, pp)}
          : {16'h0, lexp(s, 0, w == 2'h1, pp)};
        act = (w == 2'h2) ? 2'h3 : 2'h1;
        if (w != 2'h1 && (s[23:22] & act) != 2'h0) viol_exp++;
        if ((sp & act & ~s[25:24]) != 2'h0) lost = 1'b1;
        sp = s[25:24] & act;
      end
    end
    ahb(0, 32'h10, 32'h0);
    chk(r, hold);
  endtask
  initial begin
    hold = 32'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1;
    #1;
    chk(rx_bus, 32'h0);
    run(2'h0, 0, 0, 2);
    run(2'h0, 0, 1, 4);
    run(2'h0, 1, 1, 3);
    run(2'h1, 0, 1, 3);
    run(2'h1, 1, 1, 2);
    run(2'h2, 0, 1, 4);
    run(2'h2, 1, 1, 4);
    run(2'h3, 0, 1, 2);
    ahb(0, 32'h20, 32'h0);
    chk(r, 32'h0);
    ahb(0, 32'h0c, 32'h0);
    chk(r, 32'd22);
    ahb(0, 32'h08, 32'h0);
    chk(r, viol_exp);
    ahb(0, 32'h04, 32'h0);
    chk(r, {22'h0, sp, 7'h0, lost});
    // Each clear lands an idle cycle before the next read address
    ahb(1, 32'h04, 32'h1);
    ahb(1, 32'h08, 32'h0);
    ahb(1, 32'h0c, 32'h0);
    ahb(0, 32'h04, 32'h0);
    chk(r, {22'h0, sp, 8'h00});
    ahb(0, 32'h08, 32'h0);
    chk(r, 32'h0);
    ahb(0, 32'h0c, 32'h0);
    chk(r, 32'h0);
    chk(got_word, hold);
    chk({16'h0, got_cnt}, 32'd22);
    report_and_stop();
  end
endmodule
bind trp_rx_pack trp_rx_pack_chk u_chk (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .rx_valid(rx_valid), .rx_raw(rx_raw),
  .rx_sync(rx_sync), .rx_derr(rx_derr), .rx_pat(rx_pat), .rx_rd(rx_rd),
  .rx_bus(rx_bus), .rx_bus_valid(rx_bus_valid));

// File: verification/trp_fabric_sink.sv
// Fabric-side sink that keeps the last word and a word count
`timescale 1ns/1ps
module trp_fabric_sink (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [31:0] rx_bus,
  input wire logic rx_bus_valid,
  output logic [31:0] got_word,
  output logic [15:0] got_cnt
);
  // No back-pressure exists, so the sink takes every pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      got_word <= 32'h0;
      got_cnt <= 16'h0;
    end else if (rx_bus_valid) begin
      got_word <= rx_bus;
      got_cnt <= got_cnt + 16'h1;
    end
  end
endmodule

// File: verification/trp_rx_pack_monitor.sv
// Checker on the receive packer top ports
`timescale 1ns/1ps
module trp_rx_pack_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic rx_valid,
  input wire logic [19:0] rx_raw,
  input wire logic [1:0] rx_sync,
  input wire logic [1:0] rx_derr,
  input wire logic [1:0] rx_pat,
  input wire logic [1:0] rx_rd,
  input wire logic [31:0] rx_bus,
  input wire logic rx_bus_valid
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_valid_cause: assert property (rx_bus_valid |-> $past(rx_valid))
    else $error("word shown without a request");
  a_bus_holds: assert property (!rx_bus_valid |-> $stable(rx_bus))
    else $error("bus moved with no new word");
  a_byte_low: assert property (rx_bus_valid |-> rx_bus[7:0] == $past(rx_raw[7:0]))
    else $error("low byte wrong");
  a_sync_low: assert property (rx_bus_valid |-> rx_bus[10] == $past(rx_sync[0]))
    else $error("lock bit wrong");
  a_derr_low: assert property (rx_bus_valid |-> rx_bus[11] == $past(rx_derr[0]))
    else $error("disparity error bit wrong");
  a_pat_low: assert property (rx_bus_valid |-> rx_bus[12] == $past(rx_pat[0]))
    else $error("pattern bit wrong");
  a_rd_low: assert property (rx_bus_valid |-> rx_bus[15] == $past(rx_rd[0]))
    else $error("running disparity bit wrong");
  a_high_byte: assert property (rx_bus_valid && rx_bus[31:16] != 16'h0000
    |-> rx_bus[23:16] == $past(rx_raw[17:10]) && rx_bus[31] == $past(rx_rd[1]))
    else $error("high lane wrong");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  c_b2b: cover property (rx_bus_valid ##1 rx_bus_valid);
  c_high: cover property (rx_bus_valid && rx_bus[31:16] != 16'h0000);
  c_refused: cover property (rx_valid ##1 !rx_bus_valid);
endmodule
